/* core/gpc_pkg.sv */
// Constants shared by the change-interrupt port block.
// Assumes a 32-bit APB master and a word-aligned register map.
package gpc_pkg;

  // Register indices; the byte address is four times the index.
  localparam logic [9:0]  IDX_PORT      = 10'h106;
  localparam logic [9:0]  IDX_IRQ_CTL   = 10'h10b;
  localparam logic [9:0]  IDX_OPTION    = 10'h181;
  localparam logic [9:0]  IDX_DIR       = 10'h186;
  localparam logic [9:0]  IDX_PULLUP    = 10'h187;
  localparam logic [9:0]  IDX_IOC_SEL   = 10'h188;
  localparam logic [9:0]  IDX_ANALOG    = 10'h189;
  localparam logic [9:0]  IDX_EVT_STAT  = 10'h190;
  localparam logic [9:0]  IDX_EVT_CLR   = 10'h191;
  localparam logic [9:0]  IDX_EVT_EN    = 10'h192;

  localparam int          ADDR_W        = 12;
  localparam int          PIN_W         = 8;

  // Field positions.
  localparam int          BIT_CHG_FLAG  = 0;
  localparam int          BIT_CHG_EN    = 3;
  localparam int          BIT_PU_DIS_N  = 7;
  localparam int          BIT_EVT_CHG   = 0;
  localparam int          BIT_EVT_WR    = 1;
  localparam int          EVT_W         = 2;
  localparam int          ANA_W         = 2;

  // Reset values.
  localparam logic [7:0]  RST_PORT      = 8'h00;
  localparam logic [7:0]  RST_IRQ_CTL   = 8'h00;
  localparam logic [7:0]  RST_OPTION    = 8'hff;
  localparam logic [7:0]  RST_DIR       = 8'hff;
  localparam logic [7:0]  RST_PULLUP    = 8'h00;
  localparam logic [7:0]  RST_IOC_SEL   = 8'h00;
  localparam logic [1:0]  RST_ANALOG    = 2'b11;
  localparam logic [1:0]  RST_EVT       = 2'b00;
  localparam logic [31:0] RD_ZERO       = 32'h0000_0000;

endpackage : gpc_pkg

/* core/gpc_port.sv */
// Eight-pin general purpose port with pull-ups and change interrupt.
// Assumes pins are synchronous to REF_CLK_I and an APB master drives
// the register side; pad drivers resolve the three pin signals.
`timescale 1ns/1ps

module gpc_port
  import gpc_pkg::*;
(
  input  wire logic              REF_CLK_I,
  input  wire logic              RST_N_I,
  input  wire logic              PSEL_I,
  input  wire logic              PENABLE_I,
  input  wire logic              PWRITE_I,
  input  wire logic [ADDR_W-1:0] PADDR_I,
  input  wire logic [31:0]       PWDATA_I,
  output logic      [31:0]       PRDATA_O,
  output logic                   PREADY_O,
  output logic                   PSLVERR_O,
  input  wire logic [PIN_W-1:0]  PIN_IN_I,
  output logic      [PIN_W-1:0]  PIN_OUT_O,
  output logic      [PIN_W-1:0]  PIN_OE_O,
  output logic      [PIN_W-1:0]  PULLUP_EN_O,
  output logic      [ANA_W-1:0]  ANALOG_MODE_O,
  output logic                   EXT_IRQ_IN_O,
  output logic                   SLAVE_SEL_N_O,
  output logic                   WAKE_O,
  output logic                   IRQ_O
);

  // Register state.
  logic [7:0]       port_q;
  logic [7:0]       irq_ctl_q;
  logic [7:0]       option_q;
  logic [7:0]       dir_q;
  logic [7:0]       pullup_q;
  logic [7:0]       ioc_sel_q;
  logic [1:0]       analog_q;
  logic [7:0]       last_rd_q;
  logic [EVT_W-1:0] evt_stat_q;
  logic [EVT_W-1:0] evt_en_q;
  logic             ready_q;
  logic [31:0]      rdata_q;
  logic             slverr_q;

  // Bus decode; a write or read takes effect at the completing edge.
  wire        setup_w   = PSEL_I & ~ready_q;
  wire        done_w    = PSEL_I & PENABLE_I & ready_q;
  wire        wr_w      = done_w & PWRITE_I;
  wire        rd_w      = done_w & ~PWRITE_I;
  wire [9:0]  idx_w     = PADDR_I[ADDR_W-1:2];
  wire        hit_port  = idx_w == IDX_PORT;
  wire        hit_ctl   = idx_w == IDX_IRQ_CTL;
  wire        hit_opt   = idx_w == IDX_OPTION;
  wire        hit_dir   = idx_w == IDX_DIR;
  wire        hit_pu    = idx_w == IDX_PULLUP;
  wire        hit_ioc   = idx_w == IDX_IOC_SEL;
  wire        hit_ana   = idx_w == IDX_ANALOG;
  wire        hit_stat  = idx_w == IDX_EVT_STAT;
  wire        hit_clr   = idx_w == IDX_EVT_CLR;
  wire        hit_en    = idx_w == IDX_EVT_EN;
  wire        hit_any   = hit_port | hit_ctl | hit_opt | hit_dir |
                          hit_pu | hit_ioc | hit_ana | hit_stat |
                          hit_clr | hit_en;
  wire [7:0]  wd8       = PWDATA_I[7:0];

  // Pin levels as software sees them; analog pins read high.
  wire [7:0]  pins_rd   = PIN_IN_I | {6'b00_0000, analog_q};

  // Change detection against the value latched on the last access.
  // Every port read relatches, so software that polls the port while the
  // change interrupt is disarmed can hide a change from itself.
  wire [7:0]  mism_w    = (pins_rd ^ last_rd_q) & ioc_sel_q & dir_q;
  wire        chg_en    = irq_ctl_q[BIT_CHG_EN];
  wire        chg_set   = chg_en & (|mism_w);
  wire        port_acc  = done_w & hit_port;
  // A read keeps the value it returned, a write the pins as they stand.
  wire [7:0]  relatch_v = rd_w ? rdata_q[7:0] : pins_rd;

  // Read data multiplexer, sampled during the setup cycle.
  wire [7:0]  rd_mux =
      hit_port ? pins_rd :
      hit_ctl  ? irq_ctl_q :
      hit_opt  ? option_q :
      hit_dir  ? dir_q :
      hit_pu   ? pullup_q :
      hit_ioc  ? ioc_sel_q :
      hit_ana  ? {6'b00_0000, analog_q} :
      hit_stat ? {6'b00_0000, evt_stat_q} :
      hit_en   ? {6'b00_0000, evt_en_q} :
                 8'h00;

  // Flag keeps setting while the mismatch stands; set wins over clear.
  // A service routine must relatch the port before clearing, or the
  // still-standing mismatch wins and the flag stays up.
  wire        flag_wr   = wr_w & hit_ctl;
  wire        flag_d    = chg_set |
                          (flag_wr ? wd8[BIT_CHG_FLAG]
                                   : irq_ctl_q[BIT_CHG_FLAG]);

  // Sticky events: change detected and a port write seen.
  wire [EVT_W-1:0] evt_in;
  assign evt_in[BIT_EVT_CHG] = chg_set;
  assign evt_in[BIT_EVT_WR]  = wr_w & hit_port;
  wire [EVT_W-1:0] evt_clr = (wr_w & hit_clr) ? PWDATA_I[EVT_W-1:0]
                                               : RST_EVT;
  wire [EVT_W-1:0] evt_d   = evt_in | (evt_stat_q & ~evt_clr);

  // Pad controls: outputs drive where the direction bit is zero.
  // A driving pin never gets a pull-up, so it cannot fight its resistor.
  wire [7:0]  oe_d      = ~dir_q;
  wire [7:0]  pu_d      = pullup_q & dir_q &
                          {8{~option_q[BIT_PU_DIS_N]}};

  // APB handshake: no wait states, answer registered.
  // The setup edge captures read data and the error flag; PREADY_O then
  // stands for exactly the access cycle, whose closing edge commits writes.
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ready_q  <= 1'b0;
      rdata_q  <= RD_ZERO;
      slverr_q <= 1'b0;
    end else begin
      ready_q  <= setup_w;
      if (setup_w) begin
        rdata_q  <= {24'h00_0000, rd_mux};
        slverr_q <= ~hit_any;
      end
    end
  end

  // Port latch and comparison value. A read relatches the very value that
  // was returned at setup, so a pin that moves during the access phase
  // still raises a change instead of being swallowed silently.
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      port_q    <= RST_PORT;
      last_rd_q <= RST_PORT;
    end else begin
      if (wr_w && hit_port) port_q <= wd8;
      if (port_acc) last_rd_q <= relatch_v;
    end
  end

  // Configuration registers.
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      option_q  <= RST_OPTION;
      dir_q     <= RST_DIR;
      pullup_q  <= RST_PULLUP;
      ioc_sel_q <= RST_IOC_SEL;
      analog_q  <= RST_ANALOG;
      evt_en_q  <= RST_EVT;
    end else begin
      if (wr_w && hit_opt) option_q  <= wd8;
      if (wr_w && hit_dir) dir_q     <= wd8;
      if (wr_w && hit_pu)  pullup_q  <= wd8;
      if (wr_w && hit_ioc) ioc_sel_q <= wd8;
      if (wr_w && hit_ana) analog_q  <= wd8[ANA_W-1:0];
      if (wr_w && hit_en)  evt_en_q  <= wd8[EVT_W-1:0];
    end
  end

  // Interrupt control, with hardware owning the change flag.
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      irq_ctl_q  <= RST_IRQ_CTL;
      evt_stat_q <= RST_EVT;
    end else begin
      if (flag_wr) irq_ctl_q[7:1] <= wd8[7:1];
      irq_ctl_q[BIT_CHG_FLAG] <= flag_d;
      evt_stat_q <= evt_d;
    end
  end

  // Registered pin and interrupt outputs.
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      PIN_OUT_O     <= RST_PORT;
      PIN_OE_O      <= 8'h00;
      PULLUP_EN_O   <= 8'h00;
      ANALOG_MODE_O <= RST_ANALOG;
      EXT_IRQ_IN_O  <= 1'b0;
      SLAVE_SEL_N_O <= 1'b1;
      WAKE_O        <= 1'b0;
      IRQ_O         <= 1'b0;
    end else begin
      PIN_OUT_O     <= port_q;
      PIN_OE_O      <= oe_d;
      PULLUP_EN_O   <= pu_d;
      ANALOG_MODE_O <= analog_q;
      EXT_IRQ_IN_O  <= ~analog_q[0] & PIN_IN_I[0];
      SLAVE_SEL_N_O <= analog_q[1] | PIN_IN_I[1];
      WAKE_O        <= chg_en & irq_ctl_q[BIT_CHG_FLAG];
      IRQ_O         <= |(evt_d & evt_en_q);
    end
  end

  assign PRDATA_O  = rdata_q;
  assign PREADY_O  = ready_q;
  assign PSLVERR_O = slverr_q;

  // Checks on the block's own behaviour.
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (!RST_N_I);

  a_dir_drive: assert property (
    ##1 PIN_OE_O == ~$past(dir_q))
    else $error("Output enable does not follow direction.");

  a_latch_out: assert property (
    wr_w && hit_port |-> ##2 PIN_OUT_O == $past(wd8, 2))
    else $error("Pin output does not show written latch.");

  a_read_pins: assert property (
    setup_w && hit_port && !PWRITE_I |=> PRDATA_O[7:0] == $past(pins_rd))
    else $error("Port read does not return pin levels.");

  a_pullup_gate: assert property (
    option_q[BIT_PU_DIS_N] |=> PULLUP_EN_O == 8'h00)
    else $error("Pull-up active while globally disabled.");

  a_pullup_out: assert property (
    ##1 (PULLUP_EN_O & PIN_OE_O) == 8'h00)
    else $error("Pull-up enabled on a driving pin.");

  a_flag_set: assert property (
    chg_set |=> irq_ctl_q[BIT_CHG_FLAG])
    else $error("Change flag not set on mismatch.");

  a_flag_gate: assert property (
    !chg_en && !irq_ctl_q[BIT_CHG_FLAG] && !flag_wr
    |=> !irq_ctl_q[BIT_CHG_FLAG])
    else $error("Change flag set while disabled.");

  a_relatch: assert property (
    port_acc |=> last_rd_q == $past(relatch_v))
    else $error("Access did not relatch comparison value.");

  a_wake_out: assert property (
    chg_set ##1 chg_en |=> WAKE_O)
    else $error("Wake not raised for change interrupt.");

  a_analog_one: assert property (
    setup_w && hit_port && analog_q == 2'b11
    |=> PRDATA_O[1:0] == 2'b11)
    else $error("Analog pins do not read as one.");

  a_apb_answer: assert property (
    setup_w |=> PREADY_O ##1 !PREADY_O)
    else $error("Bus answer is not one cycle.");

  // Reset values, seen at the first edge after release.
  a_reset_pullup: assert property (
    $rose(RST_N_I) |-> PULLUP_EN_O == 8'h00)
    else $error("Pull-ups active after reset.");

  a_reset_dir: assert property (
    $rose(RST_N_I) |-> dir_q == RST_DIR && PIN_OE_O == 8'h00)
    else $error("Direction not all inputs after reset.");

  a_reset_analog: assert property (
    $rose(RST_N_I) |-> analog_q == RST_ANALOG)
    else $error("Shared pins not analog after reset.");

  // Register and pad behaviour.
  a_dir_write: assert property (
    wr_w && hit_dir |=> dir_q == $past(wd8))
    else $error("Direction write not taken.");

  a_latch_hold: assert property (
    !(wr_w && hit_port) |=> $stable(port_q))
    else $error("Output latch changed without a write.");

  a_pullup_sel: assert property (
    !option_q[BIT_PU_DIS_N] |=> PULLUP_EN_O == $past(pullup_q & dir_q))
    else $error("Selected pull-ups not applied to inputs.");

  // Change detection and the change flag.
  a_select_change: assert property (
    chg_en && ((pins_rd ^ last_rd_q) & ioc_sel_q & dir_q) != 8'h00
    |=> irq_ctl_q[BIT_CHG_FLAG])
    else $error("Selected input change missed.");

  a_unsel_quiet: assert property (
    ((pins_rd ^ last_rd_q) & ioc_sel_q & dir_q) == 8'h00 &&
    !irq_ctl_q[BIT_CHG_FLAG] && !(flag_wr && wd8[BIT_CHG_FLAG])
    |=> !irq_ctl_q[BIT_CHG_FLAG])
    else $error("Change flag set without a selected mismatch.");

  a_flag_hold: assert property (
    irq_ctl_q[BIT_CHG_FLAG] && !flag_wr |=> irq_ctl_q[BIT_CHG_FLAG])
    else $error("Change flag dropped without a clear.");

  a_flag_clear: assert property (
    flag_wr && !wd8[BIT_CHG_FLAG] && !chg_set
    |=> !irq_ctl_q[BIT_CHG_FLAG])
    else $error("Change flag not cleared by software.");

  a_wake_gate: assert property (
    !chg_en |=> !WAKE_O)
    else $error("Wake raised while change interrupt is off.");

  a_wake_level: assert property (
    chg_en && irq_ctl_q[BIT_CHG_FLAG] |=> WAKE_O)
    else $error("Wake missing for a pending change.");

  // Shared pin functions.
  a_ext_analog: assert property (
    analog_q[0] |=> !EXT_IRQ_IN_O)
    else $error("External interrupt seen on an analog pin.");

  a_ext_follow: assert property (
    !analog_q[0] |=> EXT_IRQ_IN_O == $past(PIN_IN_I[0]))
    else $error("External interrupt input does not follow pin.");

  a_ss_analog: assert property (
    analog_q[1] |=> SLAVE_SEL_N_O)
    else $error("Slave select active on an analog pin.");

  a_ss_follow: assert property (
    !analog_q[1] |=> SLAVE_SEL_N_O == $past(PIN_IN_I[1]))
    else $error("Slave select does not follow pin.");

  a_mode_out: assert property (
    ##1 ANALOG_MODE_O == $past(analog_q))
    else $error("Analog mode output does not follow register.");

  // Event status and the interrupt output.
  a_evt_set: assert property (
    chg_set |=> evt_stat_q[BIT_EVT_CHG])
    else $error("Change event not recorded.");

  a_port_event: assert property (
    wr_w && hit_port |=> evt_stat_q[BIT_EVT_WR])
    else $error("Port write event not recorded.");

  a_evt_sticky: assert property (
    evt_stat_q[BIT_EVT_CHG] && !(wr_w && hit_clr && PWDATA_I[BIT_EVT_CHG])
    |=> evt_stat_q[BIT_EVT_CHG])
    else $error("Change event lost without a clear.");

  a_irq_level: assert property (
    ##1 IRQ_O == |($past(evt_d) & $past(evt_en_q)))
    else $error("Interrupt output does not follow enabled events.");

  // Bus side.
  a_err_unmapped: assert property (
    setup_w && !hit_any |=> PSLVERR_O && PRDATA_O == RD_ZERO)
    else $error("Unmapped index not refused.");

  a_ready_idle: assert property (
    !PSEL_I |=> !PREADY_O)
    else $error("Bus answer without a selected transfer.");

  c_change_irq: cover property (chg_set ##1 IRQ_O);
  c_port_write: cover property (wr_w && hit_port);
  c_flag_clear: cover property (irq_ctl_q[BIT_CHG_FLAG] ##1
                                !irq_ctl_q[BIT_CHG_FLAG]);
  c_status_clear: cover property (wr_w && hit_clr);
  c_unmapped: cover property (setup_w && !hit_any);

endmodule : gpc_port

/* tb/gpc_pins.sv */
// Pin-side partner: resolves each pad from device, pull-up and outside.
// Assumes the bench drives ext_val_i/ext_en_i for switches or keypads.
`timescale 1ns/1ps

module gpc_pins
  import gpc_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic [PIN_W-1:0] out_i,
  input  wire logic [PIN_W-1:0] oe_i,
  input  wire logic [PIN_W-1:0] pu_i,
  input  wire logic [PIN_W-1:0] ext_val_i,
  input  wire logic [PIN_W-1:0] ext_en_i,
  output logic      [PIN_W-1:0] level_o
);
  logic [PIN_W-1:0] last_q = '0;

  // Remembers each level so a floating pad can wander away from it.
  always_ff @(posedge clk_i) last_q <= level_o;

  // Device drive wins, then outside drive, then pull-up, else floating.
  always_comb begin
    for (int i = 0; i < PIN_W; i++) begin
      if (oe_i[i]) level_o[i] = out_i[i];
      else if (ext_en_i[i]) level_o[i] = ext_val_i[i];
      else if (pu_i[i]) level_o[i] = 1'b1;
      else level_o[i] = ~last_q[i];
    end
  end
endmodule : gpc_pins

/* tb/gpio_port_with_change_irq_test.sv */
// Self-checking bench for the change-interrupt port over APB.
// Assumes gpc_port, gpc_pins and gpc_pkg are compiled first.
`timescale 1ns/1ps

module gpio_port_with_change_irq_test;
  import gpc_pkg::*;
  logic              clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0]       pwdata = '0, prdata, r;
  logic              pready, pslverr, ext_irq, ss_n, wake, irq, e;
  logic [7:0]        pin, pout, poe, pu, ev = 8'h00, een = 8'hff;
  logic [1:0]        ana;
  int                mismatches = 0, cmp_count = 0, cyc = 0;

  gpc_port gpc_port_inst (.REF_CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel),
    .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .PIN_IN_I(pin), .PIN_OUT_O(pout), .PIN_OE_O(poe),
    .PULLUP_EN_O(pu), .ANALOG_MODE_O(ana), .EXT_IRQ_IN_O(ext_irq),
    .SLAVE_SEL_N_O(ss_n), .WAKE_O(wake), .IRQ_O(irq));
  gpc_pins gpc_pins_inst (.clk_i(clk), .out_i(pout), .oe_i(poe), .pu_i(pu),
    .ext_val_i(ev), .ext_en_i(een), .level_o(pin));

  // Clock at 100 MHz and a cycle limit that cuts a hang short.
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      final_report();
    end
  end

  task automatic final_report();
    if (mismatches == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report

  task automatic check(input logic [31:0] got, exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask : check

  // One APB transfer; waits for PREADY, the cycle limit ends a hang.
  task automatic apb(input logic w, input logic [9:0] i, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= {24'h00_0000, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic rdchk(input logic [9:0] i, input logic [7:0] x, string m);
    apb(1'b0, i, 8'h00);
    check(r, {24'h00_0000, x}, m);
  endtask : rdchk

  task automatic t_reset();
    rdchk(IDX_DIR, 8'hff, "direction reset");
    check(pu, 8'h00, "pull-ups after reset");
    rdchk(IDX_PORT, 8'h03, "analog pins read one");
    check(ana, 2'b11, "analog mode after reset");
    check({ext_irq, ss_n}, 2'b01, "shared inputs masked");
  endtask : t_reset

  task automatic t_dir();
    apb(1'b1, IDX_ANALOG, 8'h00);
    apb(1'b1, IDX_PORT, 8'ha5);
    apb(1'b1, IDX_DIR, 8'h0f);
    ev <= 8'h06;
    repeat (3) @(posedge clk);
    check(poe, 8'hf0, "output enables");
    check(pout, 8'ha5, "output latch");
    check({ext_irq, ss_n}, 2'b01, "shared pin levels");
    check(ana, 2'b00, "digital mode selected");
    rdchk(IDX_PORT, 8'ha6, "port reads pins");
  endtask : t_dir

  task automatic t_pull();
    apb(1'b1, IDX_PULLUP, 8'hff);
    apb(1'b1, IDX_OPTION, 8'h7f);
    repeat (2) @(posedge clk);
    check(pu, 8'h0f, "pull-ups on inputs only");
    apb(1'b1, IDX_OPTION, 8'hff);
    repeat (2) @(posedge clk);
    check(pu, 8'h00, "global pull-up disable");
  endtask : t_pull

  task automatic t_irq();
    apb(1'b1, IDX_IOC_SEL, 8'h01);
    apb(1'b1, IDX_EVT_EN, 8'h01);
    apb(1'b1, IDX_IRQ_CTL, 8'h08);
    apb(1'b0, IDX_PORT, 8'h00);
    ev <= 8'h02;
    repeat (5) @(posedge clk);
    rdchk(IDX_IRQ_CTL, 8'h08, "unselected pin ignored");
    ev <= 8'h03;
    repeat (5) @(posedge clk);
    check({irq, wake}, 2'b11, "change raises irq and wake");
    apb(1'b1, IDX_EVT_EN, 8'h00);
    repeat (2) @(posedge clk);
    check(irq, 1'b0, "masked irq");
    apb(1'b1, IDX_IRQ_CTL, 8'h08);
    rdchk(IDX_IRQ_CTL, 8'h09, "flag held by mismatch");
    apb(1'b0, IDX_PORT, 8'h00);
    apb(1'b1, IDX_IRQ_CTL, 8'h08);
    rdchk(IDX_IRQ_CTL, 8'h08, "flag cleared after read");
    rdchk(IDX_EVT_STAT, 8'h03, "sticky events");
    apb(1'b1, IDX_EVT_CLR, 8'h03);
    apb(1'b1, IDX_EVT_EN, 8'h01);
    repeat (2) @(posedge clk);
    check(irq, 1'b0, "status cleared");
    rdchk(IDX_EVT_STAT, 8'h00, "events cleared");
    apb(1'b1, IDX_IRQ_CTL, 8'h00);
    ev <= 8'h02;
    repeat (5) @(posedge clk);
    rdchk(IDX_IRQ_CTL, 8'h00, "global enable off");
    apb(1'b0, 10'h107, 8'h00);
    check(e, 1'b1, "unmapped index error");
    check(r, RD_ZERO, "unmapped index reads zero");
  endtask : t_irq

  // Reset for ten cycles, then the scenarios in turn.
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_dir();
    t_pull();
    t_irq();
    final_report();
  end
endmodule : gpio_port_with_change_irq_test
